// ### lsd_consts.svh
// constants for the led sink command, setup and detection block
`ifndef LSD_CONSTS_SVH
`define LSD_CONSTS_SVH
`define LSD_SETUP_RESET      16'h716B
`define LSD_RSVD_HI_MSB      15
`define LSD_RSVD_HI_LSB      14
`define LSD_DMODE_MSB        13
`define LSD_DMODE_LSB        12
`define LSD_CHECK_MSB        9
`define LSD_CHECK_LSB        6
`define LSD_CHECK_VAL        4'h5
`define LSD_GAIN_MSB         5
`define LSD_GAIN_LSB         0
`define LSD_DMODE_FIXED      2'h3
`define LSD_DMODE_GATED      2'h2
`define LSD_CMD_LATCH        3'h0
`define LSD_CMD_DETECT       3'h1
`define LSD_CMD_WRITE        3'h4
`define LSD_CMD_READ         3'h5
`define LSD_CNT_MAX          3'h7
`define LSD_DETECT_TIME_NS   700
`define LSD_CLK_PERIOD_NS    4
`define LSD_DETECT_CYCLES    (`LSD_DETECT_TIME_NS / `LSD_CLK_PERIOD_NS)
`endif

// ### lsd_pkg.sv
// types for the led sink command, setup and detection block
package lsd_pkg;
  typedef enum logic [2:0] {
    LSD_IDLE  = 3'b001,
    LSD_FIXED = 3'b010,
    LSD_GATED = 3'b100
  } lsd_state_t;
  typedef struct packed {
    logic serial_in_line;
    logic latch_strobe;
    logic shift_edge;
    logic out_gate_n;
  } lsd_ctrl_t;
endpackage

// ### lsd_core.sv
// serial command decoder, setup register and open-circuit detection
`timescale 1ns/1ps
`include "lsd_consts.svh"
// Overview of operation
// - setup word resets to 716B.
// - setup bits 13:12 pick fixed 700ns or gate-window detection.
// - setup write takes effect only when bits 9:6 equal 0101.
// - setup bits 5:0 are the six-bit current gain, default 101011.
// - zero edges during strobe: strobe fall latches shift register.
// - one edge during strobe: strobe fall starts one detection.
// - four edges: strobe fall moves shift register into setup word.
// - five edges: setup word is shifted out msb first.
// - two, three or over five edges do nothing.
// - error flag is 0 for open circuit, else 1.
// - error flags shift out while new data shifts in.
// - fixed mode loads result 700ns after strobe fall.
// - invalid detection leaves every flag at 1.
// - gate mode window ends at gate rise; gate low throughout.
// - during detection all outputs turn on at small current.
// - one detection result is presented only once.
// - sixteen-bit shift register, last stage drives serial output outside readback.
// - outside detection, channel sinks only with gate low and latch bit 1.
module lsd_core #(
  parameter int WIDTH = 16
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  input  wire lsd_pkg::lsd_ctrl_t ctrl,
  input  wire logic [WIDTH-1:0]   open_found,
  output logic                    serial_out_line,
  output logic [WIDTH-1:0]        channel_on,
  output logic                    detect_on,
  output logic [15:0]             setup_word,
  output logic [5:0]              gain_code
);
  import lsd_pkg::*;

  localparam logic [9:0] DET_CYC = 10'(`LSD_DETECT_CYCLES);

  // ****************************************
  // edge detection and command count
  // ****************************************
  logic             strobe_d_reg;
  logic             gate_d_reg;
  logic [2:0]       edge_cnt_reg;
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] latch_reg;
  logic [15:0]      setup_reg;
  lsd_state_t       state_reg;
  logic [9:0]       timer_reg;
  logic             valid_reg;
  logic             readback_reg;
  logic [3:0]       rb_idx_reg;

  wire strobe_fall = strobe_d_reg & ~ctrl.latch_strobe;
  wire strobe_rise = ~strobe_d_reg & ctrl.latch_strobe;
  wire gate_rise   = ~gate_d_reg & ctrl.out_gate_n;

  function automatic logic is_cmd(input logic [2:0] cnt, input logic [2:0] code);
    is_cmd = (cnt == code);
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strobe_d_reg <= 1'b0;
      gate_d_reg   <= 1'b1;
    end else if (clk_en) begin
      strobe_d_reg <= ctrl.latch_strobe;
      gate_d_reg   <= ctrl.out_gate_n;
    end
  end

  // saturating so long bursts never alias back to a valid command
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      if (strobe_rise) begin
        edge_cnt_reg <= ctrl.shift_edge ? 3'h1 : 3'h0;
      end else if (ctrl.latch_strobe && ctrl.shift_edge &&
                   edge_cnt_reg != `LSD_CNT_MAX) begin
        edge_cnt_reg <= edge_cnt_reg + 3'h1;
      end
    end
  end

  wire cmd_latch  = strobe_fall & is_cmd(edge_cnt_reg, `LSD_CMD_LATCH);
  wire cmd_detect = strobe_fall & is_cmd(edge_cnt_reg, `LSD_CMD_DETECT);
  wire cmd_write  = strobe_fall & is_cmd(edge_cnt_reg, `LSD_CMD_WRITE);
  wire cmd_read   = strobe_fall & is_cmd(edge_cnt_reg, `LSD_CMD_READ);
  // counts 2, 3 and above 5 fall through every decode

  // ****************************************
  // detection sequencer
  // ****************************************
  wire det_done_fixed = (state_reg == LSD_FIXED) && (timer_reg == DET_CYC - 10'h1);
  wire det_done_gated = (state_reg == LSD_GATED) && gate_rise;
  wire det_done       = det_done_fixed | det_done_gated;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LSD_IDLE;
      timer_reg <= 10'h0;
      valid_reg <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        LSD_IDLE: begin
          timer_reg <= 10'h0;
          if (cmd_detect) begin
            if (setup_reg[`LSD_DMODE_MSB:`LSD_DMODE_LSB] == `LSD_DMODE_GATED) begin
              state_reg <= LSD_GATED;
              valid_reg <= ~ctrl.out_gate_n;
            end else begin
              state_reg <= LSD_FIXED;
              valid_reg <= ctrl.out_gate_n;
            end
          end
        end
        LSD_FIXED: begin
          timer_reg <= timer_reg + 10'h1;
          if (!ctrl.out_gate_n) valid_reg <= 1'b0;
          if (det_done) state_reg <= LSD_IDLE;
        end
        LSD_GATED: begin
          if (det_done) begin
            state_reg <= LSD_IDLE;
          end
        end
        default: state_reg <= LSD_IDLE;
      endcase
    end
  end

  assign detect_on = (state_reg != LSD_IDLE);

  // ****************************************
  // shift register, latch, setup word
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (clk_en) begin
      if (det_done) begin
        // flags load once; further shifting consumes them
        shift_reg <= valid_reg ? ~open_found : '1;
      end else if (ctrl.shift_edge && !ctrl.latch_strobe) begin
        shift_reg <= {shift_reg[WIDTH-2:0], ctrl.serial_in_line};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= '0;
    end else if (clk_en && cmd_latch) begin
      latch_reg <= shift_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      setup_reg <= `LSD_SETUP_RESET;
    end else if (clk_en && cmd_write &&
                 shift_reg[`LSD_CHECK_MSB:`LSD_CHECK_LSB] == `LSD_CHECK_VAL) begin
      setup_reg <= shift_reg[15:0];
    end
  end

  // readback walks the setup word msb first on each shift edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      readback_reg <= 1'b0;
      rb_idx_reg   <= 4'hF;
    end else if (clk_en) begin
      if (cmd_read) begin
        readback_reg <= 1'b1;
        rb_idx_reg   <= 4'hF;
      end else if (strobe_rise || cmd_detect || det_done) begin
        readback_reg <= 1'b0;
      end else if (readback_reg && ctrl.shift_edge) begin
        if (rb_idx_reg == 4'h0) readback_reg <= 1'b0;
        rb_idx_reg <= rb_idx_reg - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_line <= 1'b0;
    end else if (clk_en) begin
      serial_out_line <= readback_reg ? setup_reg[rb_idx_reg] : shift_reg[WIDTH-1];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign channel_on = detect_on ? '1 : (ctrl.out_gate_n ? '0 : latch_reg);
  assign setup_word = setup_reg;
  assign gain_code  = setup_reg[`LSD_GAIN_MSB:`LSD_GAIN_LSB];

  // ****************************************
  // checks
  // ****************************************
  property p_write_check;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && cmd_write && shift_reg[9:6] != 4'h5) |=> $stable(setup_reg);
  endproperty
  a_write_check: assert property (p_write_check) else $error("bad check bits updated setup");

  property p_write_ok;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && cmd_write && shift_reg[9:6] == 4'h5) |=> setup_reg == $past(shift_reg);
  endproperty
  a_write_ok: assert property (p_write_ok) else $error("setup write lost");

  property p_latch;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && cmd_latch) |=> latch_reg == $past(shift_reg);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not loaded");

  property p_no_latch_other;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && strobe_fall && edge_cnt_reg != 3'h0) |=> $stable(latch_reg);
  endproperty
  a_no_latch_other: assert property (p_no_latch_other) else $error("latch changed");

  property p_detect_start;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && cmd_detect && state_reg == LSD_IDLE) |=> detect_on && channel_on == '1;
  endproperty
  a_detect_start: assert property (p_detect_start) else $error("detect not started");

  property p_suppress;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && det_done && !valid_reg) |=> shift_reg == '1;
  endproperty
  a_suppress: assert property (p_suppress) else $error("suppressed flags not all ones");

  property p_fixed_time;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_reg == LSD_FIXED && timer_reg == 10'h0 && clk_en) |-> ##[1:300] state_reg == LSD_IDLE;
  endproperty
  a_fixed_time: assert property (p_fixed_time) else $error("fixed detect overran");

  property p_unused_counts;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && strobe_fall && (edge_cnt_reg == 3'h2 || edge_cnt_reg == 3'h3 ||
     edge_cnt_reg > 3'h5)) |=> $stable(setup_reg) && $stable(latch_reg);
  endproperty
  a_unused_counts: assert property (p_unused_counts) else $error("idle command acted");

  property p_gate;
    @(posedge clk_sys) disable iff (!rst_n)
    (!detect_on && ctrl.out_gate_n) |-> channel_on == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("channel on with gate high");

  // ****************************************
  // checks on counter, shifter and readback
  // ****************************************
  // a shift edge on the strobe rise cycle counts as the first edge
  property p_cnt_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && strobe_rise && !ctrl.shift_edge) |=> edge_cnt_reg == 3'h0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("edge count not cleared");

  property p_cnt_up;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && ctrl.latch_strobe && ctrl.shift_edge && !strobe_rise &&
     edge_cnt_reg != `LSD_CNT_MAX) |=> edge_cnt_reg == $past(edge_cnt_reg) + 3'h1;
  endproperty
  a_cnt_up: assert property (p_cnt_up) else $error("edge not counted");

  // wrap back to a legal code would turn a long burst into a real command
  property p_cnt_sat;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && ctrl.latch_strobe && !strobe_rise &&
     edge_cnt_reg == `LSD_CNT_MAX) |=> edge_cnt_reg == `LSD_CNT_MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("edge count wrapped");

  property p_shift;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && ctrl.shift_edge && !ctrl.latch_strobe && !det_done) |=>
      shift_reg == {$past(shift_reg[WIDTH-2:0]), $past(ctrl.serial_in_line)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift register did not shift");

  property p_sout;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !readback_reg) |=> serial_out_line == $past(shift_reg[WIDTH-1]);
  endproperty
  a_sout: assert property (p_sout) else $error("serial out not last stage");

  property p_readback_bit;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && readback_reg) |=> serial_out_line == $past(setup_reg[rb_idx_reg]);
  endproperty
  a_readback_bit: assert property (p_readback_bit) else $error("readback bit wrong");

  property p_read_start;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && cmd_read) |=> readback_reg && rb_idx_reg == 4'hF && $stable(setup_reg);
  endproperty
  a_read_start: assert property (p_read_start) else $error("readback not from msb");

  // ****************************************
  // checks on detection results and timing, and on enable freeze
  // ****************************************
  property p_flags;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && det_done && valid_reg) |=> shift_reg == ~$past(open_found);
  endproperty
  a_flags: assert property (p_flags) else $error("error flags not loaded");

  property p_gated_end;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_reg == LSD_GATED && gate_rise) |=> state_reg == LSD_IDLE;
  endproperty
  a_gated_end: assert property (p_gated_end) else $error("gate window did not close");

  property p_fixed_end;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_reg == LSD_FIXED && timer_reg == DET_CYC - 10'h1) |=> !detect_on;
  endproperty
  a_fixed_end: assert property (p_fixed_end) else $error("fixed window did not close");

  // the timer must restart from zero for every fixed detection
  property p_idle_timer;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state_reg == LSD_IDLE) |=> timer_reg == 10'h0;
  endproperty
  a_idle_timer: assert property (p_idle_timer) else $error("timer not cleared");

  // a low enable must hold every piece of state, commands included
  property p_freeze;
    @(posedge clk_sys) disable iff (!rst_n)
    (!clk_en) |=> $stable(setup_reg) && $stable(latch_reg) && $stable(shift_reg) &&
      $stable(state_reg) && $stable(edge_cnt_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

// ### lsd_ctrl_model.sv
// display controller model driving the serial, strobe and gate lines
`timescale 1ns/1ps
module lsd_ctrl_model (
  input  wire logic          clk_sys,
  input  wire logic          serial_out_line,
  output lsd_pkg::lsd_ctrl_t ctrl
);
  import lsd_pkg::*;
  initial ctrl = '{serial_in_line: 1'b0, latch_strobe: 1'b0, shift_edge: 1'b0, out_gate_n: 1'b1};
  // ************************************************************
  // serial transfer, msb first
  // ************************************************************
  // samples the far end before each edge, so a result is read only once loaded
  task automatic xfer(input logic [15:0] d, output logic [15:0] q);
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk_sys);
      q[i] = serial_out_line;
      ctrl.serial_in_line = d[i];
      ctrl.shift_edge = 1'b1;
      @(negedge clk_sys);
      ctrl.shift_edge = 1'b0;
      // released line shows the inverse, never a stale bit
      ctrl.serial_in_line = ~d[i];
      @(negedge clk_sys);
    end
  endtask
  // ************************************************************
  // strobe commands
  // ************************************************************
  task automatic cmd(input int n);
    @(negedge clk_sys);
    ctrl.latch_strobe = 1'b1;
    repeat (n) begin
      @(negedge clk_sys);
      ctrl.shift_edge = 1'b1;
      @(negedge clk_sys);
      ctrl.shift_edge = 1'b0;
    end
    @(negedge clk_sys);
    ctrl.latch_strobe = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  // full word first, then four edges; caller supplies 01, 00 and 0101 fields
  task automatic setup(input logic [15:0] w);
    logic [15:0] q;
    xfer(w, q);
    cmd(4);
  endtask
  task automatic gate(input logic v);
    @(negedge clk_sys);
    ctrl.out_gate_n = v;
  endtask
endmodule

// ### led_sink_cmd_config_detect_bench.sv
// self-checking bench for the led sink command, setup and detection block
`timescale 1ns/1ps
module led_sink_cmd_config_detect_bench;
  import lsd_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [15:0] open_found = 16'h0000;
  logic        serial_out_line;
  logic [15:0] channel_on;
  logic        detect_on;
  logic [15:0] setup_word;
  logic [5:0]  gain_code;
  lsd_ctrl_t   ctrl;
  logic [15:0] q;
  int          failures = 0;
  int          checks = 0;
  always #2 clk_sys = ~clk_sys;
  lsd_ctrl_model m (.clk_sys(clk_sys), .serial_out_line(serial_out_line), .ctrl(ctrl));
  lsd_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .ctrl(ctrl),
    .open_found(open_found), .serial_out_line(serial_out_line), .channel_on(channel_on),
    .detect_on(detect_on), .setup_word(setup_word), .gain_code(gain_code));
  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    check(setup_word, 16'h716B, "setup after reset");
    check({10'h000, gain_code}, 16'h002B, "gain after reset");
    check(channel_on, 16'h0000, "outputs after reset");
  endtask
  task automatic t_latch();
    m.xfer(16'hA5C3, q);
    m.cmd(0);
    check(channel_on, 16'h0000, "gate high blanks outputs");
    m.gate(1'b0);
    @(negedge clk_sys);
    check(channel_on, 16'hA5C3, "latched data");
  endtask
  task automatic t_setup();
    int n[3] = '{2, 3, 6};
    m.setup(16'h6155);
    check(setup_word, 16'h6155, "setup write");
    check({10'h000, gain_code}, 16'h0015, "gain field");
    m.setup(16'h6115);
    check(setup_word, 16'h6155, "bad check bits");
    foreach (n[i]) begin
      m.xfer(16'h5A5A, q);
      m.cmd(n[i]);
      check(setup_word, 16'h6155, "no-op setup");
      check(channel_on, 16'hA5C3, "no-op latch");
    end
  endtask
  task automatic t_readback();
    m.cmd(5);
    m.xfer(16'h0000, q);
    check(q, 16'h6155, "readback msb first");
  endtask
  task automatic t_gated();
    open_found = 16'h0F0A;
    m.cmd(1);
    repeat (20) @(negedge clk_sys);
    check({15'h0000, detect_on}, 16'h0001, "gated window open");
    check(channel_on, 16'hFFFF, "all outputs on");
    m.gate(1'b1);
    repeat (3) @(negedge clk_sys);
    check({15'h0000, detect_on}, 16'h0000, "gated window closed");
    m.xfer(16'h1234, q);
    check(q, 16'hF0F5, "gated flags");
    m.xfer(16'h0000, q);
    check(q, 16'h1234, "flags shown once");
  endtask
  task automatic t_fixed();
    m.setup(16'h716B);
    check(setup_word, 16'h716B, "fixed mode setup");
    open_found = 16'h8001;
    m.cmd(1);
    repeat (150) @(negedge clk_sys);
    check({15'h0000, detect_on}, 16'h0001, "fixed still detecting");
    repeat (30) @(negedge clk_sys);
    check({15'h0000, detect_on}, 16'h0000, "fixed time over");
    m.xfer(16'h0000, q);
    check(q, 16'h7FFE, "fixed flags");
    m.gate(1'b0);
    m.cmd(1);
    repeat (200) @(negedge clk_sys);
    m.xfer(16'h0000, q);
    check(q, 16'hFFFF, "suppressed detection");
  endtask
  // low enable must swallow a whole shift and a setup write
  task automatic t_freeze();
    @(negedge clk_sys);
    clk_en = 1'b0;
    m.setup(16'h6155);
    check(setup_word, 16'h716B, "frozen setup");
    check(channel_on, 16'hA5C3, "frozen latch");
    @(negedge clk_sys);
    clk_en = 1'b1;
    m.xfer(16'h0000, q);
    check(q, 16'h0000, "frozen shift register");
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_latch();
    t_setup();
    t_readback();
    t_gated();
    t_fixed();
    t_freeze();
    close_out();
  end
  // whole run is about 1200 cycles; the 20000-cycle limit is ample margin
  initial begin
    #80000;
    failures++;
    close_out();
  end
endmodule
